// *** logic/pmic_regs_pkg.sv ***
// Register map and constants for the supply control register bank
// What this block does
// R1: Each supply turns on only when its enable bit and enable pin are high.
// R2: Undervoltage lockout forces every supply enable bit to 1.
// R3: Host may write each supply enable bit to 0 or 1; value is stored.
// R4: A buck enable bit is held at 1 while that buck's pin is low.
// R5: Both linear regulator bits are held at 1 while the shared pin is low.
// R6: Buck two phase field bits 7-6, reset 10, quarter-cycle steps.
// R7: Buck three phase field bits 5-4, reset 11, same encoding.
// R8: Buck one is the phase reference, always zero offset, no field.
// R9: Bit 3 selects light-load tuning: 0 efficiency, 1 low ripple; reset 0.
// R10: Bits 2,1,0 force buck two, one, three into fixed-frequency PWM.
// R11: Core-adjust bit returns to 1 on lockout, warm reset, power-on reset, low backup.
// R12: Control two holds change trigger bit 7 and discharge enables bits 2-0, reset 0.
// R13: Trigger starts the core voltage move; hardware clears it when target reached.
// R14: Discharge bit 1 discharges a disabled converter's output; 0 never discharges.
// R15: Core-adjust 0 takes core voltage from register; 1 follows default-select pin.
// R16: Bits 5-3 of control two reset to 0 and steer nothing.
package pmic_regs_pkg;
   // Register addresses
   localparam logic [7:0] ADDR_SUPPLY_ENABLE = 8'h03;
   localparam logic [7:0] ADDR_MODE_PHASE = 8'h04;
   localparam logic [7:0] ADDR_CONTROL_TWO = 8'h05;
   // Reset values
   localparam logic [7:0] RST_SUPPLY_ENABLE = 8'hFF;
   localparam logic [7:0] RST_MODE_PHASE = 8'hB0;
   localparam logic [7:0] RST_CONTROL_TWO = 8'h40;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   // Supply enable gate fields
   localparam int BIT_BUCK_ONE_EN = 5;
   localparam int BIT_BUCK_TWO_EN = 4;
   localparam int BIT_BUCK_THREE_EN = 3;
   localparam int BIT_LINREG_TWO_EN = 2;
   localparam int BIT_LINREG_ONE_EN = 1;
   localparam logic [7:0] SUPPLY_FIXED_ONES = 8'hC1;
   // Mode and phase fields
   localparam int POS_BUCK_TWO_PHASE = 6;
   localparam int POS_BUCK_THREE_PHASE = 4;
   localparam int BIT_LOW_RIPPLE = 3;
   localparam int BIT_FORCED_BUCK_TWO = 2;
   localparam int BIT_FORCED_BUCK_ONE = 1;
   localparam int BIT_FORCED_BUCK_THREE = 0;
   localparam logic [1:0] PHASE_ZERO = 2'h0;
   // Control two fields
   localparam int BIT_CORE_GO = 7;
   localparam int BIT_CORE_ADJUST = 6;
   localparam int BIT_DISCHARGE_BUCK_TWO = 2;
   localparam int BIT_DISCHARGE_BUCK_ONE = 1;
   localparam int BIT_DISCHARGE_BUCK_THREE = 0;
   // Synchronised pin vector layout
   localparam int PIN_COUNT = 11;
   localparam int PIN_BUCK_ONE = 0;
   localparam int PIN_BUCK_TWO = 1;
   localparam int PIN_BUCK_THREE = 2;
   localparam int PIN_LINREG_SHARED = 3;
   localparam int PIN_LINREG_ONE = 4;
   localparam int PIN_LINREG_TWO = 5;
   localparam int PIN_LOCKOUT = 6;
   localparam int PIN_WARM_RESET_N = 7;
   localparam int PIN_POR = 8;
   localparam int PIN_BACKUP_LOW = 9;
   localparam int PIN_CORE_SELECT = 10;
endpackage

// *** logic/pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out
);
   logic [WIDTH-1:0] stage1_ff;
   logic [WIDTH-1:0] stage2_ff;
   logic [WIDTH-1:0] stage3_ff;
   logic [WIDTH-1:0] filt_ff;
   logic [WIDTH-1:0] nxt_filt;

   // Change accepted only once stages two and three agree
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         nxt_filt[i] = (stage2_ff[i] == stage3_ff[i]) ? stage3_ff[i] : filt_ff[i];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stage1_ff <= '0;
         stage2_ff <= '0;
         stage3_ff <= '0;
         filt_ff <= '0;
      end else begin
         stage1_ff <= pin_in;
         stage2_ff <= stage1_ff;
         stage3_ff <= stage2_ff;
         filt_ff <= nxt_filt;
      end
   end

   assign pin_out = filt_ff;
endmodule
`default_nettype wire

// *** logic/pmic_supply_control_regs.sv ***
// Supply enable, converter mode and core control register bank
`timescale 1ns/1ps
`default_nettype none
module pmic_supply_control_regs (
   input wire logic CLK,
   input wire logic NRST,
   // Register port from the serial interface
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   // Enable pins
   input wire logic BUCK_ONE_ENABLE_PIN,
   input wire logic BUCK_TWO_ENABLE_PIN,
   input wire logic BUCK_THREE_ENABLE_PIN,
   input wire logic LINREG_SHARED_ENABLE_PIN,
   input wire logic LINREG_ONE_ENABLE_PIN,
   input wire logic LINREG_TWO_ENABLE_PIN,
   // Supervisory events
   input wire logic UNDERVOLTAGE_LOCKOUT,
   input wire logic WARM_RESET_INPUT_N,
   input wire logic POWER_ON_RESET_OUT,
   input wire logic BACKUP_SUPPLY_LOW,
   input wire logic CORE_DEFAULT_SELECT_PIN,
   // From the core voltage ramp logic, same clock
   input wire logic CORE_TARGET_REACHED,
   // Supply turn-on
   output logic BUCK_ONE_ON,
   output logic BUCK_TWO_ON,
   output logic BUCK_THREE_ON,
   output logic LINREG_ONE_ON,
   output logic LINREG_TWO_ON,
   // Converter modes
   output logic [1:0] BUCK_ONE_PHASE,
   output logic [1:0] BUCK_TWO_PHASE,
   output logic [1:0] BUCK_THREE_PHASE,
   output logic LOW_RIPPLE_MODE,
   output logic BUCK_ONE_FORCED_FIXED_FREQ,
   output logic BUCK_TWO_FORCED_FIXED_FREQ,
   output logic BUCK_THREE_FORCED_FIXED_FREQ,
   // Output discharge
   output logic BUCK_ONE_DISCHARGE,
   output logic BUCK_TWO_DISCHARGE,
   output logic BUCK_THREE_DISCHARGE,
   // Core voltage control
   output logic CORE_CHANGE_GO,
   output logic CORE_FOLLOW_PIN,
   output logic CORE_DEFAULT_SELECT
);
   logic [pmic_regs_pkg::PIN_COUNT-1:0] pins_raw;
   logic [pmic_regs_pkg::PIN_COUNT-1:0] pins;

   logic buck_one_pin;
   logic buck_two_pin;
   logic buck_three_pin;
   logic linreg_shared_pin;
   logic linreg_one_pin;
   logic linreg_two_pin;
   logic lockout;
   logic core_adjust_restore;
   logic core_select_pin;

   logic wr_supply;
   logic wr_mode;
   logic wr_ctrl2;

   // Register state
   logic [7:0] supply_enable_ff;
   logic [7:0] nxt_supply_enable;
   logic [7:0] mode_phase_ff;
   logic [7:0] nxt_mode_phase;
   logic [7:0] control_two_ff;
   logic [7:0] nxt_control_two;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;

   // Output state
   logic [4:0] on_ff;
   logic [4:0] nxt_on;
   logic [2:0] discharge_ff;
   logic [2:0] nxt_discharge;
   logic [2:0] forced_ff;
   logic [2:0] nxt_forced;
   logic [1:0] phase_one_ff;
   logic [1:0] nxt_phase_one;
   logic [1:0] phase_two_ff;
   logic [1:0] nxt_phase_two;
   logic [1:0] phase_three_ff;
   logic [1:0] nxt_phase_three;
   logic low_ripple_ff;
   logic nxt_low_ripple;
   logic go_ff;
   logic nxt_go;
   logic follow_pin_ff;
   logic nxt_follow_pin;
   logic core_select_ff;
   logic nxt_core_select;

   assign pins_raw[pmic_regs_pkg::PIN_BUCK_ONE] = BUCK_ONE_ENABLE_PIN;
   assign pins_raw[pmic_regs_pkg::PIN_BUCK_TWO] = BUCK_TWO_ENABLE_PIN;
   assign pins_raw[pmic_regs_pkg::PIN_BUCK_THREE] = BUCK_THREE_ENABLE_PIN;
   assign pins_raw[pmic_regs_pkg::PIN_LINREG_SHARED] = LINREG_SHARED_ENABLE_PIN;
   assign pins_raw[pmic_regs_pkg::PIN_LINREG_ONE] = LINREG_ONE_ENABLE_PIN;
   assign pins_raw[pmic_regs_pkg::PIN_LINREG_TWO] = LINREG_TWO_ENABLE_PIN;
   assign pins_raw[pmic_regs_pkg::PIN_LOCKOUT] = UNDERVOLTAGE_LOCKOUT;
   assign pins_raw[pmic_regs_pkg::PIN_WARM_RESET_N] = WARM_RESET_INPUT_N;
   assign pins_raw[pmic_regs_pkg::PIN_POR] = POWER_ON_RESET_OUT;
   assign pins_raw[pmic_regs_pkg::PIN_BACKUP_LOW] = BACKUP_SUPPLY_LOW;
   assign pins_raw[pmic_regs_pkg::PIN_CORE_SELECT] = CORE_DEFAULT_SELECT_PIN;

   pin_sync #(
      .WIDTH(pmic_regs_pkg::PIN_COUNT)
   ) u_pin_sync (
      .clk(CLK),
      .nrst(NRST),
      .pin_in(pins_raw),
      .pin_out(pins)
   );

   assign buck_one_pin = pins[pmic_regs_pkg::PIN_BUCK_ONE];
   assign buck_two_pin = pins[pmic_regs_pkg::PIN_BUCK_TWO];
   assign buck_three_pin = pins[pmic_regs_pkg::PIN_BUCK_THREE];
   assign linreg_shared_pin = pins[pmic_regs_pkg::PIN_LINREG_SHARED];
   assign linreg_one_pin = pins[pmic_regs_pkg::PIN_LINREG_ONE];
   assign linreg_two_pin = pins[pmic_regs_pkg::PIN_LINREG_TWO];
   assign lockout = pins[pmic_regs_pkg::PIN_LOCKOUT];
   assign core_select_pin = pins[pmic_regs_pkg::PIN_CORE_SELECT];

   // Any of the four events restores the core-adjust bit
   assign core_adjust_restore = lockout
      | ~pins[pmic_regs_pkg::PIN_WARM_RESET_N]
      | pins[pmic_regs_pkg::PIN_POR]
      | pins[pmic_regs_pkg::PIN_BACKUP_LOW]; // R11

   assign wr_supply = REG_WR && (REG_ADDR == pmic_regs_pkg::ADDR_SUPPLY_ENABLE);
   assign wr_mode = REG_WR && (REG_ADDR == pmic_regs_pkg::ADDR_MODE_PHASE);
   assign wr_ctrl2 = REG_WR && (REG_ADDR == pmic_regs_pkg::ADDR_CONTROL_TWO);

   // Supply enable gate: lockout, then pin-low hold, then host write
   always_comb begin
      nxt_supply_enable = supply_enable_ff;
      if (wr_supply) begin
         nxt_supply_enable = REG_WDATA; // R3
      end
      if (!buck_one_pin) begin
         nxt_supply_enable[pmic_regs_pkg::BIT_BUCK_ONE_EN] = 1'b1; // R4
      end
      if (!buck_two_pin) begin
         nxt_supply_enable[pmic_regs_pkg::BIT_BUCK_TWO_EN] = 1'b1; // R4
      end
      if (!buck_three_pin) begin
         nxt_supply_enable[pmic_regs_pkg::BIT_BUCK_THREE_EN] = 1'b1; // R4
      end
      if (!linreg_shared_pin) begin
         nxt_supply_enable[pmic_regs_pkg::BIT_LINREG_ONE_EN] = 1'b1; // R5
         nxt_supply_enable[pmic_regs_pkg::BIT_LINREG_TWO_EN] = 1'b1; // R5
      end
      if (lockout) begin
         nxt_supply_enable = pmic_regs_pkg::RST_SUPPLY_ENABLE; // R2
      end
      // Read-only bits stay at one
      nxt_supply_enable = nxt_supply_enable | pmic_regs_pkg::SUPPLY_FIXED_ONES;
   end

   // Mode and phase register is plain read/write
   always_comb begin
      nxt_mode_phase = mode_phase_ff;
      if (wr_mode) begin
         nxt_mode_phase = REG_WDATA;
      end
   end

   // Control two: trigger set by host wins over hardware clear
   always_comb begin
      nxt_control_two = control_two_ff;
      if (CORE_TARGET_REACHED) begin
         nxt_control_two[pmic_regs_pkg::BIT_CORE_GO] = 1'b0; // R13
      end
      if (wr_ctrl2) begin
         nxt_control_two = REG_WDATA; // R12
      end
      if (core_adjust_restore) begin
         nxt_control_two[pmic_regs_pkg::BIT_CORE_ADJUST] = 1'b1; // R11
      end
   end

   // Read data held until the next read
   always_comb begin
      nxt_rdata = rdata_ff;
      if (REG_RD) begin
         case (REG_ADDR)
            pmic_regs_pkg::ADDR_SUPPLY_ENABLE: nxt_rdata = supply_enable_ff;
            pmic_regs_pkg::ADDR_MODE_PHASE: nxt_rdata = mode_phase_ff;
            pmic_regs_pkg::ADDR_CONTROL_TWO: nxt_rdata = control_two_ff;
            default: nxt_rdata = pmic_regs_pkg::READ_UNMAPPED;
         endcase
      end
   end

   // Output decode from current register contents
   always_comb begin
      nxt_on[0] = supply_enable_ff[pmic_regs_pkg::BIT_BUCK_ONE_EN] & buck_one_pin; // R1
      nxt_on[1] = supply_enable_ff[pmic_regs_pkg::BIT_BUCK_TWO_EN] & buck_two_pin; // R1
      nxt_on[2] = supply_enable_ff[pmic_regs_pkg::BIT_BUCK_THREE_EN] & buck_three_pin; // R1
      nxt_on[3] = supply_enable_ff[pmic_regs_pkg::BIT_LINREG_ONE_EN] & linreg_one_pin; // R1
      nxt_on[4] = supply_enable_ff[pmic_regs_pkg::BIT_LINREG_TWO_EN] & linreg_two_pin; // R1
      // Discharge only while the converter is off
      nxt_discharge[0] = control_two_ff[pmic_regs_pkg::BIT_DISCHARGE_BUCK_ONE]
         & ~nxt_on[0]; // R14
      nxt_discharge[1] = control_two_ff[pmic_regs_pkg::BIT_DISCHARGE_BUCK_TWO]
         & ~nxt_on[1]; // R14
      nxt_discharge[2] = control_two_ff[pmic_regs_pkg::BIT_DISCHARGE_BUCK_THREE]
         & ~nxt_on[2]; // R14
      nxt_forced[0] = mode_phase_ff[pmic_regs_pkg::BIT_FORCED_BUCK_ONE]; // R10
      nxt_forced[1] = mode_phase_ff[pmic_regs_pkg::BIT_FORCED_BUCK_TWO]; // R10
      nxt_forced[2] = mode_phase_ff[pmic_regs_pkg::BIT_FORCED_BUCK_THREE]; // R10
      nxt_phase_one = pmic_regs_pkg::PHASE_ZERO; // R8
      nxt_phase_two = mode_phase_ff[pmic_regs_pkg::POS_BUCK_TWO_PHASE +: 2]; // R6
      nxt_phase_three = mode_phase_ff[pmic_regs_pkg::POS_BUCK_THREE_PHASE +: 2]; // R7
      nxt_low_ripple = mode_phase_ff[pmic_regs_pkg::BIT_LOW_RIPPLE]; // R9
      nxt_go = control_two_ff[pmic_regs_pkg::BIT_CORE_GO]; // R13
      nxt_follow_pin = control_two_ff[pmic_regs_pkg::BIT_CORE_ADJUST]; // R15
      nxt_core_select = core_select_pin;
      // Bits 5-3 of control two feed nothing here; R16
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         supply_enable_ff <= pmic_regs_pkg::RST_SUPPLY_ENABLE;
      end else begin
         supply_enable_ff <= nxt_supply_enable;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         mode_phase_ff <= pmic_regs_pkg::RST_MODE_PHASE; // R6
      end else begin
         mode_phase_ff <= nxt_mode_phase;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         control_two_ff <= pmic_regs_pkg::RST_CONTROL_TWO; // R16
      end else begin
         control_two_ff <= nxt_control_two;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rdata_ff <= pmic_regs_pkg::READ_UNMAPPED;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         on_ff <= 5'h00;
         discharge_ff <= 3'h0;
         forced_ff <= 3'h0;
         phase_one_ff <= pmic_regs_pkg::PHASE_ZERO;
         phase_two_ff <= pmic_regs_pkg::RST_MODE_PHASE[pmic_regs_pkg::POS_BUCK_TWO_PHASE +: 2];
         phase_three_ff <=
            pmic_regs_pkg::RST_MODE_PHASE[pmic_regs_pkg::POS_BUCK_THREE_PHASE +: 2];
         low_ripple_ff <= 1'b0;
         go_ff <= 1'b0;
         follow_pin_ff <= 1'b1;
         core_select_ff <= 1'b0;
      end else begin
         on_ff <= nxt_on;
         discharge_ff <= nxt_discharge;
         forced_ff <= nxt_forced;
         phase_one_ff <= nxt_phase_one;
         phase_two_ff <= nxt_phase_two;
         phase_three_ff <= nxt_phase_three;
         low_ripple_ff <= nxt_low_ripple;
         go_ff <= nxt_go;
         follow_pin_ff <= nxt_follow_pin;
         core_select_ff <= nxt_core_select;
      end
   end

   assign REG_RDATA = rdata_ff;
   assign BUCK_ONE_ON = on_ff[0];
   assign BUCK_TWO_ON = on_ff[1];
   assign BUCK_THREE_ON = on_ff[2];
   assign LINREG_ONE_ON = on_ff[3];
   assign LINREG_TWO_ON = on_ff[4];
   assign BUCK_ONE_PHASE = phase_one_ff;
   assign BUCK_TWO_PHASE = phase_two_ff;
   assign BUCK_THREE_PHASE = phase_three_ff;
   assign LOW_RIPPLE_MODE = low_ripple_ff;
   assign BUCK_ONE_FORCED_FIXED_FREQ = forced_ff[0];
   assign BUCK_TWO_FORCED_FIXED_FREQ = forced_ff[1];
   assign BUCK_THREE_FORCED_FIXED_FREQ = forced_ff[2];
   assign BUCK_ONE_DISCHARGE = discharge_ff[0];
   assign BUCK_TWO_DISCHARGE = discharge_ff[1];
   assign BUCK_THREE_DISCHARGE = discharge_ff[2];
   assign CORE_CHANGE_GO = go_ff;
   assign CORE_FOLLOW_PIN = follow_pin_ff;
   assign CORE_DEFAULT_SELECT = core_select_ff;
endmodule
`default_nettype wire

// *** tb/supply_ctrl_sva.sv ***
// Concurrent checks for the supply control register bank
`timescale 1ns/1ps
`default_nettype none
module supply_ctrl_chk (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic BUCK_ONE_ENABLE_PIN,
   input wire logic UNDERVOLTAGE_LOCKOUT,
   input wire logic CORE_TARGET_REACHED,
   input wire logic BUCK_ONE_ON,
   input wire logic BUCK_TWO_ON,
   input wire logic [1:0] BUCK_ONE_PHASE,
   input wire logic [1:0] BUCK_TWO_PHASE,
   input wire logic [1:0] BUCK_THREE_PHASE,
   input wire logic LOW_RIPPLE_MODE,
   input wire logic BUCK_ONE_FORCED_FIXED_FREQ,
   input wire logic BUCK_TWO_FORCED_FIXED_FREQ,
   input wire logic BUCK_THREE_FORCED_FIXED_FREQ,
   input wire logic BUCK_TWO_DISCHARGE,
   input wire logic CORE_CHANGE_GO,
   input wire logic CORE_FOLLOW_PIN
);
   default clocking dclk @(posedge CLK);
   endclocking
   default disable iff (!NRST);
   a_pin_low_off:
      assert property (!BUCK_ONE_ENABLE_PIN [*8] |=> !BUCK_ONE_ON) else $error("buck on, pin low");
   a_ref_phase_zero:
      assert property (BUCK_ONE_PHASE == 2'h0) else $error("reference phase not zero");
   a_go_cleared:
      assert property (CORE_TARGET_REACHED && !REG_WR ##1 !REG_WR |=> !CORE_CHANGE_GO)
      else $error("go bit not cleared");
   a_go_set:
      assert property (REG_WR && REG_ADDR == 8'h05 && REG_WDATA[7] |-> ##2 CORE_CHANGE_GO)
      else $error("go bit not set");
   a_mode_fields:
      assert property (REG_WR && REG_ADDR == 8'h04 |-> ##2 {BUCK_TWO_PHASE, BUCK_THREE_PHASE,
         LOW_RIPPLE_MODE, BUCK_TWO_FORCED_FIXED_FREQ, BUCK_ONE_FORCED_FIXED_FREQ,
         BUCK_THREE_FORCED_FIXED_FREQ} == $past(REG_WDATA, 2)) else $error("mode outputs wrong");
   a_lockout_restore:
      assert property (UNDERVOLTAGE_LOCKOUT [*8] |=> CORE_FOLLOW_PIN)
      else $error("core adjust not restored");
   a_discharge_off_only:
      assert property (BUCK_TWO_DISCHARGE |-> !BUCK_TWO_ON) else $error("discharge while on");
   a_discharge_clear:
      assert property (REG_WR && REG_ADDR == 8'h05 && !REG_WDATA[2] |-> ##2 !BUCK_TWO_DISCHARGE)
      else $error("discharge with bit clear");
   a_follow_set:
      assert property (REG_WR && REG_ADDR == 8'h05 && REG_WDATA[6] |-> ##2 CORE_FOLLOW_PIN)
      else $error("follow pin not set");
   c_go_done: cover property (CORE_CHANGE_GO ##1 !CORE_CHANGE_GO);
   c_lockout: cover property ($rose(UNDERVOLTAGE_LOCKOUT));
   c_discharge: cover property (BUCK_TWO_DISCHARGE);
endmodule
bind pmic_supply_control_regs supply_ctrl_chk chk (.*);
`default_nettype wire

// *** tb/serial_host_model.sv ***
// Host side of the register port, one access at a time
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
   input wire logic clk,
   input wire logic [7:0] rdata,
   output logic [7:0] addr,
   output logic [7:0] wdata,
   output logic wr,
   output logic rd
);
   initial begin
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
   end
   // Idle lines show the inverse so stale values never match
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask
   task automatic read(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      addr <= ~a;
      @(posedge clk);
      #1 d = rdata;
   endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the supply control register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic CLK, NRST, REG_WR, REG_RD;
   logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
   logic BUCK_ONE_ENABLE_PIN, BUCK_TWO_ENABLE_PIN, BUCK_THREE_ENABLE_PIN;
   logic LINREG_SHARED_ENABLE_PIN, LINREG_ONE_ENABLE_PIN, LINREG_TWO_ENABLE_PIN;
   logic UNDERVOLTAGE_LOCKOUT, WARM_RESET_INPUT_N, POWER_ON_RESET_OUT, BACKUP_SUPPLY_LOW;
   logic CORE_DEFAULT_SELECT_PIN, CORE_TARGET_REACHED;
   logic BUCK_ONE_ON, BUCK_TWO_ON, BUCK_THREE_ON, LINREG_ONE_ON, LINREG_TWO_ON;
   logic [1:0] BUCK_ONE_PHASE, BUCK_TWO_PHASE, BUCK_THREE_PHASE;
   logic LOW_RIPPLE_MODE, BUCK_ONE_FORCED_FIXED_FREQ, BUCK_TWO_FORCED_FIXED_FREQ;
   logic BUCK_THREE_FORCED_FIXED_FREQ, BUCK_ONE_DISCHARGE, BUCK_TWO_DISCHARGE;
   logic BUCK_THREE_DISCHARGE, CORE_CHANGE_GO, CORE_FOLLOW_PIN, CORE_DEFAULT_SELECT;
   logic [3:0] ev;
   logic [7:0] modes [4] = '{8'h4F, 8'h00, 8'hE5, 8'h9A};
   int mismatches, checks;
   pmic_supply_control_regs dut (.*);
   serial_host_model host (.clk(CLK), .rdata(REG_RDATA), .addr(REG_ADDR), .wdata(REG_WDATA),
      .wr(REG_WR), .rd(REG_RD));
   initial begin
      CLK = 1'b0;
      forever #2.5 CLK = ~CLK;
   end
   function automatic logic [7:0] ons();
      return {3'h0, BUCK_ONE_ON, BUCK_TWO_ON, BUCK_THREE_ON, LINREG_ONE_ON, LINREG_TWO_ON};
   endfunction
   function automatic logic [7:0] dis();
      return {5'h0, BUCK_TWO_DISCHARGE, BUCK_ONE_DISCHARGE, BUCK_THREE_DISCHARGE};
   endfunction
   function automatic logic [7:0] mo();
      return {BUCK_TWO_PHASE, BUCK_THREE_PHASE, LOW_RIPPLE_MODE, BUCK_TWO_FORCED_FIXED_FREQ,
         BUCK_ONE_FORCED_FIXED_FREQ, BUCK_THREE_FORCED_FIXED_FREQ};
   endfunction
   task automatic check8(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      host.read(a, d);
      check8(d, e);
   endtask
   task automatic wait_cy(input int n);
      repeat (n) @(posedge CLK);
   endtask
   task automatic conclude();
      $display("mismatches=%0d checks=%0d", mismatches, checks);
      if (mismatches == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      wait_cy(4000);
      mismatches++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      conclude();
   end
   initial begin
      NRST = 1'b0;
      {BUCK_ONE_ENABLE_PIN, BUCK_TWO_ENABLE_PIN, BUCK_THREE_ENABLE_PIN} = 3'h7;
      {LINREG_SHARED_ENABLE_PIN, LINREG_ONE_ENABLE_PIN, LINREG_TWO_ENABLE_PIN} = 3'h7;
      {UNDERVOLTAGE_LOCKOUT, POWER_ON_RESET_OUT, BACKUP_SUPPLY_LOW} = 3'h0;
      WARM_RESET_INPUT_N = 1'b1;
      CORE_DEFAULT_SELECT_PIN = 1'b0;
      CORE_TARGET_REACHED = 1'b0;
      mismatches = 0;
      checks = 0;
      wait_cy(8);
      NRST <= 1'b1;
      wait_cy(10);
      rd_chk(8'h03, 8'hFF);
      rd_chk(8'h04, 8'hB0);
      rd_chk(8'h05, 8'h40);
      rd_chk(8'h07, 8'h00);
      check8(ons(), 8'h1F);
      host.write(8'h05, 8'hFF);
      rd_chk(8'h05, 8'hFF);
      check8({6'h0, CORE_CHANGE_GO, CORE_FOLLOW_PIN}, 8'h03);
      check8(dis(), 8'h00);
      host.write(8'h03, 8'h00);
      rd_chk(8'h03, 8'hC1);
      check8(ons(), 8'h00);
      check8(dis(), 8'h07);
      wait_cy(1);
      CORE_TARGET_REACHED <= 1'b1;
      wait_cy(1);
      CORE_TARGET_REACHED <= 1'b0;
      wait_cy(2);
      #1 check8({7'h0, CORE_CHANGE_GO}, 8'h00);
      rd_chk(8'h05, 8'h7F);
      wait_cy(1);
      BUCK_ONE_ENABLE_PIN <= 1'b0;
      wait_cy(10);
      BUCK_ONE_ENABLE_PIN <= 1'b1;
      rd_chk(8'h03, 8'hE1);
      wait_cy(8);
      #1 check8(ons(), 8'h10);
      wait_cy(1);
      LINREG_SHARED_ENABLE_PIN <= 1'b0;
      wait_cy(10);
      LINREG_SHARED_ENABLE_PIN <= 1'b1;
      rd_chk(8'h03, 8'hE7);
      wait_cy(1);
      LINREG_ONE_ENABLE_PIN <= 1'b0;
      wait_cy(8);
      #1 check8(ons(), 8'h11);
      for (int i = 0; i < 4; i++) begin
         host.write(8'h04, modes[i]);
         wait_cy(1);
         #1 check8(mo(), modes[i]);
         rd_chk(8'h04, modes[i]);
         check8({6'h0, BUCK_ONE_PHASE}, 8'h00);
      end
      // One supervisory event per pass: lockout, warm reset, power-on, backup low
      for (int i = 0; i < 4; i++) begin
         host.write(8'h03, 8'h00);
         host.write(8'h05, 8'h00);
         rd_chk(8'h05, 8'h00);
         ev = 4'h8 >> i;
         wait_cy(1);
         UNDERVOLTAGE_LOCKOUT <= ev[3];
         WARM_RESET_INPUT_N <= !ev[2];
         POWER_ON_RESET_OUT <= ev[1];
         BACKUP_SUPPLY_LOW <= ev[0];
         wait_cy(10);
         {UNDERVOLTAGE_LOCKOUT, POWER_ON_RESET_OUT, BACKUP_SUPPLY_LOW} <= 3'h0;
         WARM_RESET_INPUT_N <= 1'b1;
         wait_cy(8);
         rd_chk(8'h05, 8'h40);
         rd_chk(8'h03, (i == 0) ? 8'hFF : 8'hC1);
      end
      wait_cy(1);
      CORE_DEFAULT_SELECT_PIN <= 1'b1;
      wait_cy(8);
      #1 check8({6'h0, CORE_FOLLOW_PIN, CORE_DEFAULT_SELECT}, 8'h03);
      conclude();
   end
endmodule
`default_nettype wire
